// >>> hdl/snoop_steer.sv
// snoop-control steering top with wishbone mode/status registers
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/100ps

// Overview of operation
// - a snooped write holds off memory while the cache is searched and a hit is invalidated first.
// - a snooped read holds off memory while the cache is searched for a matching dirty line.
// - a clean hit or a miss on a snooped read releases memory to answer normally.
// - a dirty hit on a snooped read is supplied by the processor with memory inhibited from the end of the search to the end of the cycle.
// - later reads of that line keep being supplied from cache until it is written back.
// - whichever processor masters the local bus drives the other processor's snoop-control code.
// - with the vme snoop enable clear no vme slave cycle is snooped.
// - with the vme snoop enable set a vme write is presented with the invalidate code.
// - with the vme snoop enable set a vme read is presented with the supply code.
// - with the expansion snoop enable set expansion dma cycles are snooped like vme cycles.
// - the active-low per-cycle expansion request also snoops that cycle, ored with the enable.
// - with two processors writes invalidate in both, and only one processor snoops reads.
// - both snoop enables live in the software-written mode register.
// - block transfers are not snooped and are flagged so software keeps coherency itself.
module snoop_steer (
  input  wire logic                           CLK_I,
  input  wire logic                           RST_I,
  input  wire logic [3:0]                     ADR_I,
  input  wire logic [31:0]                    DAT_I,
  output logic      [31:0]                    DAT_O,
  input  wire logic [3:0]                     SEL_I,
  input  wire logic                           WE_I,
  input  wire logic                           CYC_I,
  input  wire logic                           STB_I,
  output logic                                ACK_O,
  input  wire snoop_pkg::ext_cycle_s          VME_CYCLE_I,
  input  wire snoop_pkg::ext_cycle_s          EXP_CYCLE_I,
  input  wire logic                           EXPANSION_CYCLE_SNOOP_REQUEST_N_I,
  input  wire logic [1:0]                     LOCAL_GRANT_I,
  input  wire logic [3:0]                     USER_ATTRIBUTE_OUTPUTS_I,
  output logic      [3:0]                     SNOOP_CONTROL_INPUTS_O,
  input  wire snoop_pkg::lookup_result_s [1:0] CACHE_RESULT_I,
  output logic      [1:0]                     CACHE_LOOKUP_O,
  output logic      [1:0]                     CACHE_INVALIDATE_O,
  output logic      [1:0]                     MEM_STALL_O,
  output logic      [1:0]                     MEM_INHIBIT_O,
  output logic      [1:0]                     CACHE_SUPPLY_O
);

  typedef struct packed {
    logic [snoop_pkg::MODE_W-1:0] mode;
    logic                         blt_seen;
    logic                         ack;
    logic [31:0]                  dat;
    logic [3:0]                   sc;
  } top_state_s;

  top_state_s             st_q;
  top_state_s             st_d;
  logic                   req_n_sync;
  logic                   ext_valid;
  logic                   ext_we;
  logic                   ext_blt;
  logic                   ext_snoop;
  snoop_pkg::snoop_code_t ext_code;
  snoop_pkg::snoop_code_t cpu_code [1:0];
  logic                   bus_req;
  logic                   wr_stb;
  logic                   dual;
  logic                   rdsel;
  logic [1:0]             busy;

  // the request pin is driven by a module on another timing domain
  sync2 #(
    .W    (1),
    .INIT (1'b1)
  ) u_req_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   (EXPANSION_CYCLE_SNOOP_REQUEST_N_I),
    .q_o   (req_n_sync)
  );

  assign dual  = st_q.mode[snoop_pkg::MODE_DUAL_BIT];
  assign rdsel = st_q.mode[snoop_pkg::MODE_RDSEL_BIT];

  // one external master owns local memory at a time; vme taken first
  always_comb begin
    ext_valid = VME_CYCLE_I.valid | EXP_CYCLE_I.valid;
    if (VME_CYCLE_I.valid) begin
      ext_we    = VME_CYCLE_I.we;
      ext_blt   = VME_CYCLE_I.blt;
      ext_snoop = st_q.mode[snoop_pkg::MODE_VME_BIT];
    end else begin
      ext_we    = EXP_CYCLE_I.we;
      ext_blt   = EXP_CYCLE_I.blt;
      ext_snoop = st_q.mode[snoop_pkg::MODE_EXP_BIT] | ~req_n_sync;
    end
    ext_code = snoop_pkg::SC_NONE;
    // block transfers slip past the snoop logic, so never ask for it
    if (ext_valid && ext_snoop && !ext_blt) begin
      ext_code = ext_we ? snoop_pkg::SC_INVAL : snoop_pkg::SC_SUPPLY;
    end
  end

  // per-processor code: external cycle, else the other cpu's attributes
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      cpu_code[k] = snoop_pkg::SC_NONE;
      if (ext_valid) begin
        cpu_code[k] = ext_code; // writes reach both caches
        // two responders would fight on the data bus
        if (ext_code == snoop_pkg::SC_SUPPLY && dual && (k != int'(rdsel))) begin
          cpu_code[k] = snoop_pkg::SC_NONE;
        end
      end else if (LOCAL_GRANT_I[1-k]) begin
        cpu_code[k] = USER_ATTRIBUTE_OUTPUTS_I[2*(1-k) +: 2];
      end
      if (k == 1 && !dual) begin
        cpu_code[k] = snoop_pkg::SC_NONE;
      end
    end
  end

  // register slave and state update
  always_comb begin
    st_d    = st_q;
    bus_req = CYC_I & STB_I;
    // a write lands at the edge where the master sees ack
    wr_stb  = bus_req & st_q.ack & WE_I;
    st_d.ack = bus_req & ~st_q.ack;
    if (st_d.ack) begin
      case (ADR_I)
        snoop_pkg::MODE_OFS: begin
          st_d.dat = {28'h0000000, st_q.mode};
        end
        snoop_pkg::STATUS_OFS: begin
          st_d.dat = {27'h0000000, MEM_INHIBIT_O, busy, st_q.blt_seen};
        end
        default: begin
          st_d.dat = 32'h00000000;
        end
      endcase
    end
    if (wr_stb && SEL_I[0] && ADR_I == snoop_pkg::MODE_OFS) begin
      st_d.mode = DAT_I[snoop_pkg::MODE_W-1:0];
    end
    if (wr_stb && SEL_I[0] && ADR_I == snoop_pkg::STATUS_OFS &&
        DAT_I[snoop_pkg::STAT_BLT_BIT]) begin
      st_d.blt_seen = 1'b0;
    end
    // set after clear so a new block transfer is never lost
    if (ext_valid && ext_blt) begin
      st_d.blt_seen = 1'b1;
    end
    st_d.sc = {cpu_code[1], cpu_code[0]};
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= '{mode: snoop_pkg::MODE_RESET, blt_seen: 1'b0, ack: 1'b0,
                dat: 32'h00000000, sc: 4'h0};
    end else begin
      st_q <= st_d;
    end
  end

  assign ACK_O                  = st_q.ack;
  assign DAT_O                  = st_q.dat;
  assign SNOOP_CONTROL_INPUTS_O = st_q.sc;

  // responders see the registered code, one cycle behind the cycle start
  for (genvar g = 0; g < 2; g++) begin : g_rsp
    snoop_responder u_rsp (
      .clk_i        (CLK_I),
      .rst_i        (RST_I),
      .active_i     (ext_valid),
      .code_i       (st_q.sc[2*g +: 2]),
      .result_i     (CACHE_RESULT_I[g]),
      .lookup_o     (CACHE_LOOKUP_O[g]),
      .stall_o      (MEM_STALL_O[g]),
      .invalidate_o (CACHE_INVALIDATE_O[g]),
      .inhibit_o    (MEM_INHIBIT_O[g]),
      .supply_o     (CACHE_SUPPLY_O[g]),
      .busy_o       (busy[g])
    );
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  property p_vme_off;
    VME_CYCLE_I.valid && !st_q.mode[snoop_pkg::MODE_VME_BIT]
      |=> SNOOP_CONTROL_INPUTS_O == 4'h0;
  endproperty
  a_vme_off: assert property (p_vme_off) else $error("vme snooped while off");

  property p_vme_write;
    VME_CYCLE_I.valid && VME_CYCLE_I.we && !VME_CYCLE_I.blt &&
    st_q.mode[snoop_pkg::MODE_VME_BIT]
      |=> SNOOP_CONTROL_INPUTS_O[1:0] == snoop_pkg::SC_INVAL;
  endproperty
  a_vme_write: assert property (p_vme_write) else $error("vme write code wrong");

  property p_vme_read;
    VME_CYCLE_I.valid && !VME_CYCLE_I.we && !VME_CYCLE_I.blt && !dual &&
    st_q.mode[snoop_pkg::MODE_VME_BIT]
      |=> SNOOP_CONTROL_INPUTS_O[1:0] == snoop_pkg::SC_SUPPLY;
  endproperty
  a_vme_read: assert property (p_vme_read) else $error("vme read code wrong");

  property p_exp_enable;
    !VME_CYCLE_I.valid && EXP_CYCLE_I.valid && !EXP_CYCLE_I.blt && EXP_CYCLE_I.we &&
    st_q.mode[snoop_pkg::MODE_EXP_BIT]
      |=> SNOOP_CONTROL_INPUTS_O[1:0] == snoop_pkg::SC_INVAL;
  endproperty
  a_exp_enable: assert property (p_exp_enable) else $error("dma not snooped");

  property p_exp_request;
    !VME_CYCLE_I.valid && EXP_CYCLE_I.valid && !EXP_CYCLE_I.blt && !req_n_sync
      |=> SNOOP_CONTROL_INPUTS_O != 4'h0;
  endproperty
  a_exp_request: assert property (p_exp_request) else $error("request ignored");

  property p_single_supplier;
    !(SNOOP_CONTROL_INPUTS_O[1:0] == snoop_pkg::SC_SUPPLY &&
      SNOOP_CONTROL_INPUTS_O[3:2] == snoop_pkg::SC_SUPPLY);
  endproperty
  a_single_supplier: assert property (p_single_supplier) else $error("two suppliers");

  property p_upa_cross;
    !ext_valid && LOCAL_GRANT_I == 2'h1 && dual
      |=> SNOOP_CONTROL_INPUTS_O[3:2] == $past(USER_ATTRIBUTE_OUTPUTS_I[1:0]);
  endproperty
  a_upa_cross: assert property (p_upa_cross) else $error("attribute not steered");

  property p_blt_flag;
    ext_valid && ext_blt |=> st_q.blt_seen && SNOOP_CONTROL_INPUTS_O == 4'h0;
  endproperty
  a_blt_flag: assert property (p_blt_flag) else $error("block transfer snooped");

  property p_idle_none;
    !ext_valid && LOCAL_GRANT_I == 2'h0 |=> SNOOP_CONTROL_INPUTS_O == 4'h0;
  endproperty
  a_idle_none: assert property (p_idle_none) else $error("code without snoop");

  property p_mode_write;
    wr_stb && SEL_I[0] && ADR_I == snoop_pkg::MODE_OFS
      |=> st_q.mode == $past(DAT_I[snoop_pkg::MODE_W-1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not stored");

  property p_ack_pulse;
    ACK_O |=> !ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  property p_ack_answer;
    bus_req && !ACK_O
      |=> ACK_O;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no bus answer");

  property p_mode_read;
    bus_req && !ACK_O && !WE_I && ADR_I == snoop_pkg::MODE_OFS
      |=> DAT_O == {28'h0000000, $past(st_q.mode)};
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");

  property p_unmapped_read;
    bus_req && !ACK_O && ADR_I != snoop_pkg::MODE_OFS && ADR_I != snoop_pkg::STATUS_OFS
      |=> DAT_O == 32'h00000000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_status_read;
    bus_req && !ACK_O && !WE_I && ADR_I == snoop_pkg::STATUS_OFS
      |=> DAT_O[snoop_pkg::STAT_BLT_BIT] == $past(st_q.blt_seen);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status flag wrong");

  property p_blt_clear;
    wr_stb && SEL_I[0] && ADR_I == snoop_pkg::STATUS_OFS && DAT_I[snoop_pkg::STAT_BLT_BIT]
      && !(ext_valid && ext_blt) |=> !st_q.blt_seen;
  endproperty
  a_blt_clear: assert property (p_blt_clear) else $error("flag not cleared");

  property p_blt_sticky;
    st_q.blt_seen && !wr_stb
      |=> st_q.blt_seen;
  endproperty
  a_blt_sticky: assert property (p_blt_sticky) else $error("flag lost");

  property p_dual_write;
    ext_valid && ext_we && ext_snoop && !ext_blt && dual
      |=> SNOOP_CONTROL_INPUTS_O == {snoop_pkg::SC_INVAL, snoop_pkg::SC_INVAL};
  endproperty
  a_dual_write: assert property (p_dual_write) else $error("write not to both");

  property p_dual_read0;
    ext_valid && !ext_we && ext_snoop && !ext_blt && dual && !rdsel
      |=> SNOOP_CONTROL_INPUTS_O == {snoop_pkg::SC_NONE, snoop_pkg::SC_SUPPLY};
  endproperty
  a_dual_read0: assert property (p_dual_read0) else $error("read not to cpu0");

  property p_dual_read1;
    ext_valid && !ext_we && ext_snoop && !ext_blt && dual && rdsel
      |=> SNOOP_CONTROL_INPUTS_O == {snoop_pkg::SC_SUPPLY, snoop_pkg::SC_NONE};
  endproperty
  a_dual_read1: assert property (p_dual_read1) else $error("read not to cpu1");

  property p_single_cpu;
    !dual
      |=> SNOOP_CONTROL_INPUTS_O[3:2] == snoop_pkg::SC_NONE;
  endproperty
  a_single_cpu: assert property (p_single_cpu) else $error("absent cpu snooped");

  property p_exp_off;
    !VME_CYCLE_I.valid && EXP_CYCLE_I.valid && req_n_sync &&
    !st_q.mode[snoop_pkg::MODE_EXP_BIT] |=> SNOOP_CONTROL_INPUTS_O == 4'h0;
  endproperty
  a_exp_off: assert property (p_exp_off) else $error("dma snooped while off");

  property p_upa_cpu0;
    !ext_valid && LOCAL_GRANT_I == 2'h2
      |=> SNOOP_CONTROL_INPUTS_O[1:0] == $past(USER_ATTRIBUTE_OUTPUTS_I[3:2]);
  endproperty
  a_upa_cpu0: assert property (p_upa_cpu0) else $error("cpu0 code not steered");

  property p_inval_stalled;
    CACHE_INVALIDATE_O != 2'h0
      |-> (CACHE_INVALIDATE_O & ~MEM_STALL_O) == 2'h0;
  endproperty
  a_inval_stalled: assert property (p_inval_stalled) else $error("invalidate unstalled");

  property p_supply_held;
    MEM_INHIBIT_O != 2'h0 && ext_valid
      |=> MEM_INHIBIT_O == $past(MEM_INHIBIT_O);
  endproperty
  a_supply_held: assert property (p_supply_held) else $error("inhibit dropped early");

  c_vme_write: cover property (VME_CYCLE_I.valid && VME_CYCLE_I.we ##1
                               SNOOP_CONTROL_INPUTS_O[1:0] == snoop_pkg::SC_INVAL);
  c_exp_req:   cover property (EXP_CYCLE_I.valid && !req_n_sync &&
                               !st_q.mode[snoop_pkg::MODE_EXP_BIT]);
  c_dual_read: cover property (dual && rdsel && VME_CYCLE_I.valid && !VME_CYCLE_I.we ##1
                               SNOOP_CONTROL_INPUTS_O[3:2] == snoop_pkg::SC_SUPPLY);
  c_reg_write: cover property (wr_stb ##3 ACK_O);

endmodule

// >>> hdl/snoop_pkg.sv
// shared constants and carriers for snoop-control steering
package snoop_pkg;

  // register map, byte addresses on the wishbone slave
  localparam logic [3:0] MODE_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  // mode register fields
  localparam int         MODE_VME_BIT   = 0;
  localparam int         MODE_EXP_BIT   = 1;
  localparam int         MODE_DUAL_BIT  = 2;
  localparam int         MODE_RDSEL_BIT = 3;
  localparam int         MODE_W         = 4;
  localparam logic [3:0] MODE_RESET     = 4'h0;

  // status register fields
  localparam int STAT_BLT_BIT   = 0;
  localparam int STAT_BUSY_LSB  = 1;
  localparam int STAT_INHIB_LSB = 3;

  // snoop-control encodings
  typedef logic [1:0] snoop_code_t;
  localparam snoop_code_t SC_NONE   = 2'h0;
  localparam snoop_code_t SC_SUPPLY = 2'h1;
  localparam snoop_code_t SC_INVAL  = 2'h2;

  // one external master cycle into local memory
  typedef struct packed {
    logic valid;
    logic we;
    logic blt;
  } ext_cycle_s;

  // answer of one processor's cache search
  typedef struct packed {
    logic done;
    logic hit;
    logic dirty;
  } lookup_result_s;

  typedef enum logic [2:0] {RSP_IDLE, RSP_SEARCH, RSP_INVAL, RSP_SUPPLY, RSP_HOLD} rsp_state_e;

endpackage

// >>> hdl/sync2.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module sync2 #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_s;

  sync_state_s st_q, st_d;

  if (W < 1) begin : g_chk
    $error("sync2 width must be at least one");
  end

  always_comb begin
    st_d      = st_q;
    st_d.meta = d_i;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= {INIT, INIT};
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.sync;
endmodule

// >>> hdl/snoop_responder.sv
// per-processor snoop responder: stall, search, invalidate or supply
`timescale 1ns/100ps
module snoop_responder (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      active_i,
  input  wire snoop_pkg::snoop_code_t    code_i,
  input  wire snoop_pkg::lookup_result_s result_i,
  output logic                           lookup_o,
  output logic                           stall_o,
  output logic                           invalidate_o,
  output logic                           inhibit_o,
  output logic                           supply_o,
  output logic                           busy_o
);
  typedef struct packed {
    snoop_pkg::rsp_state_e state;
    logic                  wr;
  } rsp_s;

  rsp_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    case (st_q.state)
      snoop_pkg::RSP_IDLE: begin
        if (active_i && code_i != snoop_pkg::SC_NONE) begin
          st_d.state = snoop_pkg::RSP_SEARCH;
          st_d.wr    = (code_i == snoop_pkg::SC_INVAL);
        end
      end
      snoop_pkg::RSP_SEARCH: begin
        if (result_i.done) begin
          if (st_q.wr) begin
            // line dropped while memory still held off
            st_d.state = result_i.hit ? snoop_pkg::RSP_INVAL : snoop_pkg::RSP_HOLD;
          end else if (result_i.hit && result_i.dirty) begin
            // dirty stays set until write-back, so repeats land here too
            st_d.state = snoop_pkg::RSP_SUPPLY;
          end else begin
            st_d.state = snoop_pkg::RSP_HOLD;
          end
        end
      end
      snoop_pkg::RSP_INVAL:  st_d.state = snoop_pkg::RSP_HOLD;
      snoop_pkg::RSP_SUPPLY: if (!active_i) st_d.state = snoop_pkg::RSP_IDLE;
      snoop_pkg::RSP_HOLD:   if (!active_i) st_d.state = snoop_pkg::RSP_IDLE;
      default:               st_d.state = snoop_pkg::RSP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '{state: snoop_pkg::RSP_IDLE, wr: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // memory held off during search and invalidate
  assign lookup_o     = (st_q.state == snoop_pkg::RSP_SEARCH);
  assign stall_o      = lookup_o | invalidate_o;
  assign invalidate_o = (st_q.state == snoop_pkg::RSP_INVAL);
  assign inhibit_o    = (st_q.state == snoop_pkg::RSP_SUPPLY);
  assign supply_o     = inhibit_o;
  assign busy_o       = (st_q.state != snoop_pkg::RSP_IDLE);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_read_stall;
    st_q.state == snoop_pkg::RSP_IDLE && active_i && code_i == snoop_pkg::SC_SUPPLY
      |=> stall_o && lookup_o;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read snoop not stalled");

  property p_inval_then_release;
    $rose(invalidate_o) |-> stall_o ##1 (!stall_o && !invalidate_o);
  endproperty
  a_inval_then_release: assert property (p_inval_then_release) else $error("bad invalidate");

  property p_clean_release;
    lookup_o && result_i.done && !st_q.wr && !(result_i.hit && result_i.dirty)
      |=> !stall_o && !inhibit_o;
  endproperty
  a_clean_release: assert property (p_clean_release) else $error("clean read held");

  property p_dirty_supply;
    lookup_o && result_i.done && !st_q.wr && result_i.hit && result_i.dirty
      |=> supply_o && inhibit_o && !stall_o;
  endproperty
  a_dirty_supply: assert property (p_dirty_supply) else $error("dirty not supplied");

  c_supply: cover property (lookup_o ##1 supply_o [*2]);
endmodule

// >>> bench/ext_master_model.sv
// far-side master model: vme slave and expansion dma cycles into local memory
`timescale 1ns/100ps
module ext_master_model (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             go_i,
  input  wire logic             exp_i,
  input  wire logic             we_i,
  input  wire logic             blt_i,
  input  wire logic             req_i,
  input  wire logic [3:0]       len_i,
  output snoop_pkg::ext_cycle_s vme_o,
  output snoop_pkg::ext_cycle_s exp_o,
  output logic                  req_n_o
);
  logic [3:0] cnt_q;

  // released qualifiers show the inverse of their last value, never a stale copy
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q   <= 4'h0;
      vme_o   <= '0;
      exp_o   <= '0;
      req_n_o <= 1'b1;
    end else if (go_i && cnt_q == 4'h0) begin
      cnt_q   <= len_i + 4'h1;
      vme_o   <= {!exp_i, we_i, blt_i};
      exp_o   <= {exp_i, we_i, blt_i};
      req_n_o <= !req_i;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      // two idle cycles follow every cycle so responders return to idle
      if (cnt_q == 4'h2) begin
        vme_o   <= {1'b0, ~vme_o.we, ~vme_o.blt};
        exp_o   <= {1'b0, ~exp_o.we, ~exp_o.blt};
        req_n_o <= 1'b1;
      end
    end
  end
endmodule

// >>> bench/tb_top.sv
// self-checking bench for snoop-control steering
`timescale 1ns/100ps
module tb_top;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic [3:0]                adr = 4'h0;
  logic [31:0]               dat_w = 32'h0;
  logic [31:0]               dat_r;
  logic                      we = 1'b0;
  logic                      cyc = 1'b0;
  logic                      stb = 1'b0;
  logic                      ack;
  logic [1:0]                grant = 2'h1;
  logic [3:0]                attr = 4'h0;
  logic [3:0]                snp_code;
  logic [3:0]                u;
  snoop_pkg::lookup_result_s cres = '0;
  logic [1:0]                lk, inv, stl, inh, sup;
  logic [1:0]                inh_p = 2'h0;
  logic                      v_p = 1'b0;
  snoop_pkg::ext_cycle_s     vme, expc;
  logic                      req_n;
  logic                      go = 1'b0, m_exp = 1'b0, m_we = 1'b0, m_blt = 1'b0;
  logic                      m_req = 1'b0, probe = 1'b0;
  logic [31:0]               note_q[4][$];
  int                        miscompares = 0, compares = 0, cycles = 0;
  integer                    seed = 32'h7447AB10;

  always #2 clk = ~clk;

  snoop_steer dut (.CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r),
    .SEL_I(4'hF), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .VME_CYCLE_I(vme),
    .EXP_CYCLE_I(expc), .EXPANSION_CYCLE_SNOOP_REQUEST_N_I(req_n), .LOCAL_GRANT_I(grant),
    .USER_ATTRIBUTE_OUTPUTS_I(attr), .SNOOP_CONTROL_INPUTS_O(snp_code),
    .CACHE_RESULT_I({cres, cres}), .CACHE_LOOKUP_O(lk), .CACHE_INVALIDATE_O(inv),
    .MEM_STALL_O(stl), .MEM_INHIBIT_O(inh), .CACHE_SUPPLY_O(sup));

  ext_master_model master (.clk_i(clk), .rst_i(rst), .go_i(go), .exp_i(m_exp), .we_i(m_we),
    .blt_i(m_blt), .req_i(m_req), .len_i(4'h8), .vme_o(vme), .exp_o(expc), .req_n_o(req_n));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic note(input int k, input logic [31:0] v);
    note_q[k].push_back(v);
  endtask

  task automatic pop(input int k, input string what, input logic [31:0] seen);
    if (note_q[k].size() == 0) begin
      check({what, " unexpected"}, seen, 32'h0);
    end else begin
      check(what, seen, note_q[k].pop_front());
    end
  endtask

  // classic single cycle; the wait is bounded by the cycle ceiling
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    note(0, exp);
    wb(1'b0, a, 32'h0);
  endtask

  // code probed late in the cycle so the synchronised request has landed
  task automatic ext(input logic e, input logic w, input logic b, input logic r,
                     input logic [3:0] code);
    note(1, {28'h0, code});
    @(posedge clk);
    go    <= 1'b1;
    m_exp <= e;
    m_we  <= w;
    m_blt <= b;
    m_req <= r;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic done(input string name);
    repeat (4) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      check("pending notes", 32'(note_q[k].size()), 32'h0);
    end
    $display("test %s finished", name);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    if (!rst) begin
      if (ack === 1'b1 && we === 1'b0) pop(0, "read data", dat_r);
      if (probe) pop(1, "snoop code", {28'h0, snp_code});
      if (inv !== 2'b00) pop(2, "invalidate", {26'h0, stl, inv, inh});
      if (lk !== 2'b00) check("lookup stall", {30'h0, lk & stl}, {30'h0, lk});
      if (inh !== 2'b00 && inh_p === 2'b00) pop(3, "inhibit", {26'h0, stl, inh, sup});
      if (inh === 2'b00 && inh_p !== 2'b00) check("inhibit end", {31'h0, v_p}, 32'h0);
      inh_p = inh;
      v_p   = vme.valid | expc.valid;
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end

  // cres fields: done, hit, dirty
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(snoop_pkg::MODE_OFS, 32'h0);
    rd(snoop_pkg::STATUS_OFS, 32'h0);
    rd(4'h8, 32'h0);
    wb(1'b1, 4'h8, 32'hFFFF_FFFF);
    wb(1'b1, snoop_pkg::MODE_OFS, 32'hFFFF_FFFF);
    rd(snoop_pkg::MODE_OFS, 32'h0000_000F);
    done("registers");
    wb(1'b1, snoop_pkg::MODE_OFS, 32'h4);
    cres <= 3'b111;
    ext(1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
    ext(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    ext(1'b1, 1'b1, 1'b0, 1'b0, 4'h0);
    done("disabled");
    wb(1'b1, snoop_pkg::MODE_OFS, 32'h5);
    cres <= 3'b110;
    note(2, 32'h3C);
    ext(1'b0, 1'b1, 1'b0, 1'b0, 4'hA);
    cres <= 3'b100;
    ext(1'b0, 1'b1, 1'b0, 1'b0, 4'hA);
    cres <= 3'b111;
    note(3, 32'h05);
    ext(1'b0, 1'b0, 1'b0, 1'b0, 4'h1);
    note(3, 32'h05);
    ext(1'b0, 1'b0, 1'b0, 1'b0, 4'h1);
    cres <= 3'b110;
    ext(1'b0, 1'b0, 1'b0, 1'b0, 4'h1);
    wb(1'b1, snoop_pkg::MODE_OFS, 32'hD);
    cres <= 3'b111;
    note(3, 32'h0A);
    ext(1'b0, 1'b0, 1'b0, 1'b0, 4'h4);
    done("vme");
    wb(1'b1, snoop_pkg::MODE_OFS, 32'h2);
    note(2, 32'h14);
    ext(1'b1, 1'b1, 1'b0, 1'b0, 4'h2);
    note(3, 32'h05);
    ext(1'b1, 1'b0, 1'b0, 1'b0, 4'h1);
    wb(1'b1, snoop_pkg::MODE_OFS, 32'h0);
    note(2, 32'h14);
    ext(1'b1, 1'b1, 1'b0, 1'b1, 4'h2);
    done("expansion");
    wb(1'b1, snoop_pkg::MODE_OFS, 32'h1);
    ext(1'b0, 1'b1, 1'b1, 1'b0, 4'h0);
    rd(snoop_pkg::STATUS_OFS, 32'h1);
    wb(1'b1, snoop_pkg::STATUS_OFS, 32'h1);
    rd(snoop_pkg::STATUS_OFS, 32'h0);
    done("block transfer");
    wb(1'b1, snoop_pkg::MODE_OFS, 32'h4);
    cres <= 3'b100;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      probe <= 1'b0;
      u = 4'($random(seed));
      attr  <= u;
      grant <= i[0] ? 2'h2 : 2'h1;
      note(1, i[0] ? {30'h0, u[3:2]} : {28'h0, u[1:0], 2'b00});
      @(posedge clk);
      probe <= 1'b1;
    end
    @(posedge clk);
    probe <= 1'b0;
    grant <= 2'h0;
    note(1, 32'h0);
    @(posedge clk);
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    done("attributes");
    close_out();
  end
endmodule
